/* rtl/ssrs_pkg.sv */
// package: constants and types for the status register set bank
package ssrs_pkg;
  localparam int SSRS_NUM_SETS = 11;
  localparam int SSRS_SEL_W = 4;
  localparam int SSRS_DATA_W = 16;
  // register set selectors
  localparam logic [3:0] SSRS_SET_DEVICE = 4'h0;
  localparam logic [3:0] SSRS_SET_OPER = 4'h1;
  localparam logic [3:0] SSRS_SET_OPER_CAL = 4'h2;
  localparam logic [3:0] SSRS_SET_OPER_LLF = 4'h3;
  localparam logic [3:0] SSRS_SET_OPER_MEAS = 4'h4;
  localparam logic [3:0] SSRS_SET_OPER_SENSE = 4'h5;
  localparam logic [3:0] SSRS_SET_OPER_TRIG = 4'h6;
  localparam logic [3:0] SSRS_SET_OPER_ULF = 4'h7;
  localparam logic [3:0] SSRS_SET_QUES = 4'h8;
  localparam logic [3:0] SSRS_SET_QUES_CAL = 4'h9;
  localparam logic [3:0] SSRS_SET_QUES_POW = 4'hA;
  // writable field: low 15 bits, bit 15 forced to zero
  localparam logic [15:0] SSRS_VALUE_MASK = 16'h7FFF;
  // preset values
  localparam logic [15:0] SSRS_ENABLE_PRESET = 16'h0000;
  localparam logic [15:0] SSRS_NTR_PRESET = 16'h0000;
  localparam logic [15:0] SSRS_PTR_PRESET = 16'h7FFF;
  localparam logic [15:0] SSRS_EVENT_RESET = 16'h0000;
  localparam logic SSRS_QEN_PRESET = 1'b0;
  localparam logic [7:0] SSRS_IEEE_RESET = 8'h00;
  // sub-commands
  typedef enum logic [2:0] {
    SSRS_CMD_EVENT = 3'h0,
    SSRS_CMD_COND = 3'h1,
    SSRS_CMD_ENABLE = 3'h2,
    SSRS_CMD_NTR = 3'h3,
    SSRS_CMD_PTR = 3'h4
  } ssrs_cmd_t;
endpackage : ssrs_pkg

/* rtl/ssrs_set_if.sv */
// interface: per-set control lines from the bank to one register set
`timescale 1ns/1ns
interface ssrs_set_if;
  import ssrs_pkg::*;
  logic sel;
  logic wr_enable;
  logic wr_ntr;
  logic wr_ptr;
  logic rd_event;
  logic [15:0] wdata;
  logic [15:0] cond;
  logic [15:0] event_q;
  logic [15:0] enable_q;
  logic [15:0] ntr_q;
  logic [15:0] ptr_q;
  logic summary;
  modport bank (output sel, wr_enable, wr_ntr, wr_ptr, rd_event, wdata,
    input cond, event_q, enable_q, ntr_q, ptr_q, summary);
  modport regset (input sel, wr_enable, wr_ntr, wr_ptr, rd_event, wdata,
    output cond, event_q, enable_q, ntr_q, ptr_q, summary);
endinterface : ssrs_set_if

/* rtl/ssrs_regset.sv */
// one status register set: condition, event, enable, transition filters
`timescale 1ns/1ns
module ssrs_regset
  import ssrs_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic clear_status_i,
  input wire logic preset_i,
  input wire logic [15:0] cond_i,
  ssrs_set_if.regset bus
);
  logic [15:0] cond_prev;
  logic [15:0] evt;
  logic [15:0] ena;
  logic [15:0] ntr;
  logic [15:0] ptr;
  logic [15:0] next_cond_prev;
  logic [15:0] next_evt;
  logic [15:0] next_ena;
  logic [15:0] next_ntr;
  logic [15:0] next_ptr;
  logic [15:0] cond;
  logic [15:0] hit;

  //////////////////////////////////////////////////////////////////////////
  // next values; a set of an event bit beats the read or clear-status clear
  always_comb begin
    cond = cond_i & SSRS_VALUE_MASK;
    next_cond_prev = cond;
    hit = (~cond & cond_prev & ntr) | (cond & ~cond_prev & ptr);
    next_evt = evt;
    if ((bus.sel && bus.rd_event) || clear_status_i) begin
      next_evt = SSRS_EVENT_RESET;
    end
    next_evt = next_evt | hit;
    next_ena = ena;
    next_ntr = ntr;
    next_ptr = ptr;
    if (preset_i) begin
      next_ena = SSRS_ENABLE_PRESET;
      next_ntr = SSRS_NTR_PRESET;
      next_ptr = SSRS_PTR_PRESET;
    end else if (bus.sel) begin
      if (bus.wr_enable) begin
        next_ena = bus.wdata & SSRS_VALUE_MASK;
      end
      if (bus.wr_ntr) begin
        next_ntr = bus.wdata & SSRS_VALUE_MASK;
      end
      if (bus.wr_ptr) begin
        next_ptr = bus.wdata & SSRS_VALUE_MASK;
      end
    end
  end

  // power-on reset clears events and presets filters and enables
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cond_prev <= 16'h0000;
      evt <= SSRS_EVENT_RESET;
      ena <= SSRS_ENABLE_PRESET;
      ntr <= SSRS_NTR_PRESET;
      ptr <= SSRS_PTR_PRESET;
    end else begin
      cond_prev <= next_cond_prev;
      evt <= next_evt;
      ena <= next_ena;
      ntr <= next_ntr;
      ptr <= next_ptr;
    end
  end

  assign bus.cond = cond;
  assign bus.event_q = evt;
  assign bus.enable_q = ena;
  assign bus.ntr_q = ntr;
  assign bus.ptr_q = ptr;
  assign bus.summary = |(evt & ena);
endmodule : ssrs_regset

/* rtl/ssrs_bank.sv */
// top: bank of eleven status register sets with command port
//
// Contract
// - power-on and preset restore filters, enables and queue enable; reset and clear do not.
// - clear-status and power-on clear all event registers and the queue flag; others leave them.
// - standard enable and request enable clear only at power-on; status byte also on clear-status.
// - a condition query returns the 15-bit condition of the set, 0..32767, without changing it.
// - an event query returns the event register, 0..32767, and clears it.
// - a status access with no sub-command is an event query.
// - an enable write stores the low 15 bits and forces bit 15 to zero.
// - an enable query returns the enable register, 0..32767.
// - a negative-transition write stores the low 15 bits with bit 15 zero.
// - a negative-transition query returns that register, 0..32767.
// - a positive-transition write stores the low 15 bits with bit 15 zero.
// - a positive-transition query returns that register, 0..32767.
// - every set has its own five registers reached by the same sub-commands.
// - an event bit latches on a falling condition with NTR set or rising with PTR set.
`timescale 1ns/1ns
module ssrs_bank
  import ssrs_pkg::*;
#(
  parameter int NUM_SETS = SSRS_NUM_SETS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [3:0] cmd_set_i,
  input wire logic cmd_has_sub_i,
  input wire logic [2:0] cmd_sub_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic clear_status_i,
  input wire logic reset_cmd_i,
  input wire logic preset_i,
  input wire logic queue_push_i,
  input wire logic [7:0] ese_wdata_i,
  input wire logic ese_we_i,
  input wire logic [7:0] sre_wdata_i,
  input wire logic sre_we_i,
  input wire logic [7:0] sesr_set_i,
  input wire logic stb_read_i,
  input wire logic [15:0] cond_i [NUM_SETS],
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  output logic cmd_error_o,
  output logic [NUM_SETS-1:0] summary_o,
  output logic queue_enable_o,
  output logic queue_pending_o,
  output logic [7:0] ese_o,
  output logic [7:0] sre_o,
  output logic [7:0] sesr_o
);
  // per-set links and read values
  ssrs_set_if sif [NUM_SETS] ();
  logic [15:0] rd_mux [NUM_SETS];
  // command decode
  ssrs_cmd_t sub;
  logic set_ok;
  logic sub_ok;
  logic ro_write;
  logic refuse;
  logic accept;
  // registered state
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic cmd_error;
  logic queue_en;
  logic queue_pend;
  logic [7:0] ese;
  logic [7:0] sre;
  logic [7:0] sesr;
  // next values
  logic next_rsp_valid;
  logic [15:0] next_rsp_data;
  logic next_cmd_error;
  logic next_queue_en;
  logic next_queue_pend;
  logic [7:0] next_ese;
  logic [7:0] next_sre;
  logic [7:0] next_sesr;

  //////////////////////////////////////////////////////////////////////////
  // decode: missing sub-command falls back to event query
  always_comb begin
    sub = cmd_has_sub_i ? ssrs_cmd_t'(cmd_sub_i) : SSRS_CMD_EVENT;
    set_ok = (cmd_set_i < 4'(NUM_SETS));
    sub_ok = !cmd_has_sub_i || (cmd_sub_i <= 3'h4);
    // event and condition are query-only, so writing them is refused
    ro_write = cmd_write_i && ((sub == SSRS_CMD_EVENT) || (sub == SSRS_CMD_COND));
    // a refused command must leave every register of every set untouched
    refuse = cmd_valid_i && (!set_ok || !sub_ok || ro_write);
    accept = cmd_valid_i && !refuse;
  end

  // one register set per selector, each with its own five registers
  genvar g;
  generate
    for (g = 0; g < NUM_SETS; g++) begin : g_set
      // select rises in a set only for an accepted command naming it; the write and read strobes go to every set
      assign sif[g].sel = accept && (cmd_set_i == 4'(g));
      assign sif[g].wr_enable = cmd_write_i && (sub == SSRS_CMD_ENABLE);
      assign sif[g].wr_ntr = cmd_write_i && (sub == SSRS_CMD_NTR);
      assign sif[g].wr_ptr = cmd_write_i && (sub == SSRS_CMD_PTR);
      assign sif[g].rd_event = !cmd_write_i && (sub == SSRS_CMD_EVENT);
      assign sif[g].wdata = cmd_wdata_i;
      // summary leaves the bank per set; wiring it into a parent is done outside
      assign summary_o[g] = sif[g].summary;

      // clear-status and preset reach every set in the same cycle
      ssrs_regset u_set (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clear_status_i(clear_status_i),
        .preset_i(preset_i),
        .cond_i(cond_i[g]),
        .bus(sif[g])
      );

      // read mux per set; values already carry bit 15 at zero
      always_comb begin
        case (sub)
          SSRS_CMD_COND: rd_mux[g] = sif[g].cond;
          SSRS_CMD_ENABLE: rd_mux[g] = sif[g].enable_q;
          SSRS_CMD_NTR: rd_mux[g] = sif[g].ntr_q;
          SSRS_CMD_PTR: rd_mux[g] = sif[g].ptr_q;
          default: rd_mux[g] = sif[g].event_q;
        endcase
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // response next values; a refused command answers with an error pulse only
  always_comb begin
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    next_cmd_error = refuse;
    // only an accepted query produces an answer
    if (accept && !cmd_write_i) begin
      next_rsp_valid = 1'b1;
      next_rsp_data = 16'h0000;
      // an out-of-range set never reaches here, so no fallback set is needed
      for (int i = 0; i < NUM_SETS; i++) begin
        if (cmd_set_i == 4'(i)) begin
          next_rsp_data = rd_mux[i] & SSRS_VALUE_MASK;
        end
      end
    end
  end

  // response registers; data holds until the next answer
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      cmd_error <= 1'b0;
    end else begin
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      cmd_error <= next_cmd_error;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // error queue next values; reset_cmd_i touches nothing in this block
  always_comb begin
    // the queue enable moves only on preset, so it has no write path here
    next_queue_en = preset_i ? SSRS_QEN_PRESET : queue_en;
    // a push in the clearing cycle survives the clear
    next_queue_pend = (clear_status_i ? 1'b0 : queue_pend) | queue_push_i;
  end

  // error queue registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      queue_en <= SSRS_QEN_PRESET;
      queue_pend <= 1'b0;
    end else begin
      queue_en <= next_queue_en;
      queue_pend <= next_queue_pend;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // standard registers next values
  always_comb begin
    // ese and sre keep their value through clear-status and preset
    next_ese = ese_we_i ? ese_wdata_i : ese;
    next_sre = sre_we_i ? sre_wdata_i : sre;
    // a status bit raised in the clearing cycle survives the clear
    next_sesr = (clear_status_i || stb_read_i) ? SSRS_IEEE_RESET : sesr;
    next_sesr = next_sesr | sesr_set_i;
  end

  // standard registers; power-on reset clears the standard enables as well
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ese <= SSRS_IEEE_RESET;
      sre <= SSRS_IEEE_RESET;
      sesr <= SSRS_IEEE_RESET;
    end else begin
      ese <= next_ese;
      sre <= next_sre;
      sesr <= next_sesr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // response outputs straight from their registers
  assign rsp_valid_o = rsp_valid;
  assign rsp_data_o = rsp_data;
  assign cmd_error_o = cmd_error;

  // status outputs straight from their registers
  assign queue_enable_o = queue_en;
  assign queue_pending_o = queue_pend;
  assign ese_o = ese;
  assign sre_o = sre;
  assign sesr_o = sesr;
endmodule : ssrs_bank

/* dv/ssrs_bank_sva.sv */
// checker: port-level assertions for the status register set bank
`timescale 1ns/1ns
module ssrs_bank_sva
  import ssrs_pkg::*;
#(
  parameter int NUM_SETS = SSRS_NUM_SETS
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [3:0] cmd_set_i,
  input wire logic cmd_has_sub_i,
  input wire logic [2:0] cmd_sub_i,
  input wire logic clear_status_i,
  input wire logic preset_i,
  input wire logic queue_push_i,
  input wire logic ese_we_i,
  input wire logic sre_we_i,
  input wire logic [7:0] sesr_set_i,
  input wire logic [15:0] cond_i [NUM_SETS],
  input wire logic rsp_valid_o,
  input wire logic [15:0] rsp_data_o,
  input wire logic cmd_error_o,
  input wire logic queue_pending_o,
  input wire logic [7:0] ese_o,
  input wire logic [7:0] sre_o,
  input wire logic [7:0] sesr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic good;
  // sets above ten do not exist
  assign good = cmd_set_i < 4'hB;
  query_answer_a: assert property (cmd_valid_i && !cmd_write_i && good &&
    (!cmd_has_sub_i || cmd_sub_i < 3'h5) |=> rsp_valid_o && !cmd_error_o)
    else $error("query not answered");
  bit15_clear_a: assert property (rsp_valid_o |-> !rsp_data_o[15])
    else $error("answer has bit 15 set");
  bad_set_a: assert property (cmd_valid_i && !good |=> cmd_error_o && !rsp_valid_o)
    else $error("bad set not refused");
  ro_write_a: assert property (cmd_valid_i && cmd_write_i && cmd_has_sub_i &&
    cmd_sub_i < 3'h2 |=> cmd_error_o)
    else $error("write to query-only accepted");
  // condition held steady so the answer does not hinge on sampling lag
  cond_data_a: assert property (cmd_valid_i && !cmd_write_i && good && cmd_has_sub_i &&
    cmd_sub_i == 3'h1 && $stable(cond_i[cmd_set_i]) |=>
    rsp_data_o == ($past(cond_i[cmd_set_i]) & SSRS_VALUE_MASK))
    else $error("condition answer wrong");
  sesr_clear_a: assert property (clear_status_i && sesr_set_i == 8'h00 |=> sesr_o == 8'h00)
    else $error("status byte not cleared");
  ese_keep_a: assert property ((clear_status_i || preset_i) && !ese_we_i && !sre_we_i
    |=> $stable(ese_o) && $stable(sre_o))
    else $error("standard enables disturbed");
  queue_clear_a: assert property (clear_status_i && !queue_push_i |=> !queue_pending_o)
    else $error("queue not cleared");
endmodule : ssrs_bank_sva
bind ssrs_bank ssrs_bank_sva #(.NUM_SETS(NUM_SETS)) ssrs_bank_sva_inst (.*);

/* dv/tb.sv */
// self-checking bench for the status register set bank
`timescale 1ns/1ns
module tb;
  import ssrs_pkg::*;
  logic clk_i = 1'h0, resetn_i = 1'h0, cmd_valid_i = 1'h0, cmd_write_i = 1'h0;
  logic cmd_has_sub_i = 1'h0, clear_status_i = 1'h0, reset_cmd_i = 1'h0, preset_i = 1'h0;
  logic queue_push_i = 1'h0, ese_we_i = 1'h0, sre_we_i = 1'h0, stb_read_i = 1'h0;
  logic [3:0] cmd_set_i = 4'h0;
  logic [2:0] cmd_sub_i = 3'h0;
  logic [15:0] cmd_wdata_i = 16'h0000, rsp_data_o, r;
  logic [7:0] ese_wdata_i = 8'h00, sre_wdata_i = 8'h00, sesr_set_i = 8'h00, ese_o, sre_o, sesr_o;
  logic [15:0] cond_i [SSRS_NUM_SETS];
  logic [SSRS_NUM_SETS-1:0] summary_o;
  logic rsp_valid_o, cmd_error_o, queue_enable_o, queue_pending_o, v, e;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 clk_i = ~clk_i;
  ssrs_bank ssrs_bank_inst (.*);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one command, held over one rising edge; answer read a cycle later
  task automatic cmd(input logic w, input logic [3:0] s, input logic hs, input logic [2:0] sb,
      input logic [15:0] d);
    @(negedge clk_i);
    {cmd_valid_i, cmd_write_i, cmd_set_i, cmd_has_sub_i, cmd_sub_i, cmd_wdata_i} =
      {1'h1, w, s, hs, sb, d};
    @(negedge clk_i);
    cmd_valid_i = 1'h0;
    {v, e, r} = {rsp_valid_o, cmd_error_o, rsp_data_o};
  endtask : cmd
  task automatic q(input logic [3:0] s, input logic hs, input logic [2:0] sb,
      input logic [15:0] x);
    cmd(1'h0, s, hs, sb, 16'h0000);
    chk({v, e, r}, {2'h2, x});
  endtask : q
  task automatic pulse(ref logic p);
    @(negedge clk_i);
    p = 1'h1;
    @(negedge clk_i);
    p = 1'h0;
  endtask : pulse
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    conclude();
  end
  initial begin
    foreach (cond_i[i]) cond_i[i] = 16'h0000;
    repeat (16) @(negedge clk_i);
    resetn_i = 1'h1;
    for (int s = 0; s < SSRS_NUM_SETS; s++) begin
      q(s[3:0], 1'h1, SSRS_CMD_ENABLE, SSRS_ENABLE_PRESET);
      q(s[3:0], 1'h1, SSRS_CMD_NTR, SSRS_NTR_PRESET);
      q(s[3:0], 1'h1, SSRS_CMD_PTR, SSRS_PTR_PRESET);
    end
    chk({17'h00000, queue_enable_o}, {17'h00000, SSRS_QEN_PRESET});
    $display("test presets done");
    cond_i[5] = 16'h80A0;
    repeat (2) @(negedge clk_i);
    q(4'h5, 1'h1, SSRS_CMD_COND, 16'h00A0);
    q(4'h5, 1'h1, SSRS_CMD_COND, 16'h00A0);
    q(4'h6, 1'h1, SSRS_CMD_EVENT, 16'h0000);
    q(4'h5, 1'h0, SSRS_CMD_ENABLE, 16'h00A0);
    q(4'h5, 1'h1, SSRS_CMD_EVENT, 16'h0000);
    cmd(1'h1, 4'h5, 1'h1, SSRS_CMD_NTR, 16'hFFA0);
    q(4'h5, 1'h1, SSRS_CMD_NTR, 16'h7FA0);
    cmd(1'h1, 4'h5, 1'h1, SSRS_CMD_NTR, 16'h0020);
    cmd(1'h1, 4'h5, 1'h1, SSRS_CMD_ENABLE, 16'h0020);
    cond_i[5] = 16'h0000;
    repeat (2) @(negedge clk_i);
    chk({7'h00, summary_o}, 18'h00020);
    q(4'h5, 1'h1, SSRS_CMD_EVENT, 16'h0020);
    $display("test transitions done");
    cond_i[5] = 16'h0001;
    pulse(preset_i);
    chk({17'h00000, queue_enable_o}, {17'h00000, SSRS_QEN_PRESET});
    q(4'h5, 1'h1, SSRS_CMD_ENABLE, 16'h0000);
    q(4'h5, 1'h1, SSRS_CMD_EVENT, 16'h0001);
    cond_i[5] = 16'h0003;
    pulse(clear_status_i);
    q(4'h5, 1'h1, SSRS_CMD_EVENT, 16'h0000);
    cmd(1'h1, 4'h5, 1'h1, SSRS_CMD_ENABLE, 16'hF234);
    pulse(reset_cmd_i);
    pulse(clear_status_i);
    q(4'h5, 1'h1, SSRS_CMD_ENABLE, 16'h7234);
    for (int s = 0; s < SSRS_NUM_SETS; s++) begin
      cmd(1'h1, s[3:0], 1'h1, SSRS_CMD_PTR, 16'hFF00 | 16'(s));
    end
    for (int s = 0; s < SSRS_NUM_SETS; s++) begin
      q(s[3:0], 1'h1, SSRS_CMD_PTR, 16'h7F00 | 16'(s));
    end
    // refused: bad set, unknown sub-command, then writes to event and condition
    for (int k = 0; k < 6; k++) begin
      cmd(k[0] || (k > 3), k < 2 ? 4'hB : 4'h1, 1'h1, k < 4 ? 3'h5 : k[2:0] - 3'h4, 16'hFFFF);
      chk({v, e, 16'h0000}, 18'h10000);
    end
    q(4'h1, 1'h1, SSRS_CMD_PTR, 16'h7F01);
    $display("test commands done");
    {ese_wdata_i, sre_wdata_i, sesr_set_i} = {8'h3C, 8'hC3, 8'h11};
    pulse(ese_we_i);
    pulse(sre_we_i);
    sesr_set_i = 8'h00;
    pulse(queue_push_i);
    chk({queue_pending_o, sesr_o, 1'h0, ese_o}, {1'h1, 8'h11, 1'h0, 8'h3C});
    pulse(clear_status_i);
    chk({queue_pending_o, sesr_o, 1'h0, sre_o}, {1'h0, 8'h00, 1'h0, 8'hC3});
    // a status byte read also empties the standard event status
    sesr_set_i = 8'h05;
    @(negedge clk_i);
    sesr_set_i = 8'h00;
    chk({10'h000, sesr_o}, 18'h00005);
    pulse(stb_read_i);
    chk({10'h000, sesr_o}, 18'h00000);
    resetn_i = 1'h0;
    repeat (2) @(negedge clk_i);
    resetn_i = 1'h1;
    chk({2'h0, ese_o, sre_o}, 18'h00000);
    q(4'h5, 1'h1, SSRS_CMD_ENABLE, 16'h0000);
    $display("test standard registers done");
    conclude();
  end
endmodule : tb
